/* File: src/cfg_guard.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Low is dominant, high is recessive
// - Bus recessive until reset pin released
// - Path carries bit rates to 1 Mbit/s
// - Any detector sets shared error flag
// - Disable bit suppresses all four detectors
// - Long dominant transmit latches transmitter off
// - Four unfollowed dominant edges latch off
// - Long dominant bus flags, transmitter stays
// - Four echo misses latch transmitter off
// - Transmit time-out nominally 700 us
// - Bus dominant time-out nominally 700 us
module cfg_guard
  import cfg_pkg::*;
#(
  parameter int unsigned TX_TO_CYC  = TX_DOM_TO_CYC,
  parameter int unsigned BUS_TO_CYC = BUS_DOM_TO_CYC
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Controller side
  input  wire logic can_tx,
  output logic      can_rx,
  // Analog front end
  input  wire logic bus_rx,
  input  wire logic rx_echo,
  output logic      bus_drive_n,
  // Chip reset pin condition met
  input  wire logic rst_pin_ok,
  // Control bits from the serial control channel
  input  wire logic fault_guard_off,
  input  wire logic status_clear,
  // Status toward the serial control channel
  output logic      can_error,
  output logic      err_tx_timeout,
  output logic      err_bus_rec,
  output logic      err_bus_dom,
  output logic      err_rx_rec,
  output logic      tx_off
);
  localparam int TW = $clog2(TX_TO_CYC + 2);
  localparam int BW = $clog2(BUS_TO_CYC + 2);

  logic          can_tx_d_ff;
  logic [TW-1:0] tx_cnt_ff;
  logic [BW-1:0] bus_cnt_ff;
  logic          trip_bus;
  logic          trip_echo;
  logic          tx_fall;
  logic          guard_on;
  logic          tx_long;
  logic          bus_long;

  assign guard_on = !fault_guard_off;
  assign tx_fall  = (can_tx_d_ff == LVL_REC) && (can_tx == LVL_DOM);

  // Time-out conditions; the counters saturate one past the limit, so these
  // stay high while the line stays dominant and no clear or disable restarts the count
  assign tx_long  = (tx_cnt_ff > TW'(TX_TO_CYC));
  assign bus_long = (bus_cnt_ff > BW'(BUS_TO_CYC));

  // ==========================================================================
  // Edge history of the transmit input
  // ==========================================================================
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      can_tx_d_ff <= LVL_REC;
    end else begin
      can_tx_d_ff <= can_tx;
    end
  end

  // ==========================================================================
  // Transmitter drive, one register stage; one bit time is 40 cycles so
  // a single cycle of latency is harmless even at the top rate
  // ==========================================================================
  // gated dominant drive
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_drive_n <= LVL_REC;
    end else if (!rst_pin_ok || tx_off) begin
      bus_drive_n <= LVL_REC;
    end else begin
      bus_drive_n <= can_tx;
    end
  end

  // Receive path from the bus comparator, one register stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      can_rx <= LVL_REC;
    end else begin
      can_rx <= bus_rx;
    end
  end

  // ==========================================================================
  // Dominant time counters, saturate one past the limit
  // ==========================================================================
  // A clear restarts both counters; a line still dominant past the limit in
  // the clear cycle keeps its latch set, as a real fault must
  // transmit dominant timer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_cnt_ff <= '0;
    end else if (can_tx == LVL_REC || !guard_on || status_clear) begin
      tx_cnt_ff <= '0;
    end else if (tx_cnt_ff <= TW'(TX_TO_CYC)) begin
      tx_cnt_ff <= tx_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_cnt_ff <= '0;
    end else if (bus_rx == LVL_REC || !guard_on || status_clear) begin
      bus_cnt_ff <= '0;
    end else if (bus_cnt_ff <= BW'(BUS_TO_CYC)) begin
      bus_cnt_ff <= bus_cnt_ff + 1'b1;
    end
  end

  // ==========================================================================
  // Follow checkers for the bus and the internal echo
  // ==========================================================================
  // Arming waits for the pin condition and a running driver: with the
  // driver held recessive the bus cannot follow, so misses would be false
  // bus follow check
  cfg_miss_cnt u_bus_miss (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .enable  (guard_on),
    .clear   (status_clear),
    .tx_fall (tx_fall && rst_pin_ok && !tx_off),
    .watched (bus_rx),
    .trip    (trip_bus)
  );

  cfg_miss_cnt u_echo_miss (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .enable  (guard_on),
    .clear   (status_clear),
    .tx_fall (tx_fall && rst_pin_ok && !tx_off),
    .watched (rx_echo),
    .trip    (trip_echo)
  );

  // ==========================================================================
  // Latched status; a new fault in the clear cycle wins over the clear
  // ==========================================================================
  // transmit time-out latch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      err_tx_timeout <= 1'b0;
    end else if (guard_on && tx_long) begin
      err_tx_timeout <= 1'b1;
    end else if (status_clear) begin
      err_tx_timeout <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      err_bus_rec <= 1'b0;
    end else if (guard_on && trip_bus) begin
      err_bus_rec <= 1'b1;
    end else if (status_clear) begin
      err_bus_rec <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      err_bus_dom <= 1'b0;
    end else if (guard_on && bus_long) begin
      err_bus_dom <= 1'b1;
    end else if (status_clear) begin
      err_bus_dom <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      err_rx_rec <= 1'b0;
    end else if (guard_on && trip_echo) begin
      err_rx_rec <= 1'b1;
    end else if (status_clear) begin
      err_rx_rec <= 1'b0;
    end
  end

  // ==========================================================================
  // Shared flag and transmitter shutdown, one cycle behind the latches
  // ==========================================================================
  // shared error flag
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      can_error <= 1'b0;
    end else begin
      can_error <= err_tx_timeout | err_bus_rec | err_bus_dom | err_rx_rec;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_off <= 1'b0;
    end else begin
      tx_off <= err_tx_timeout | err_bus_rec | err_rx_rec;
    end
  end
endmodule // cfg_guard
`default_nettype wire

/* File: src/cfg_pkg.sv */
package cfg_pkg;
  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned BIT_RATE_MAX    = 1_000_000;   // Bits per second
  localparam int unsigned TX_DOM_TO_US    = 700;         // Nominal, 525..875 window
  localparam int unsigned TX_DOM_MIN_US   = 525;
  localparam int unsigned TX_DOM_MAX_US   = 875;
  localparam int unsigned BUS_DOM_TO_US   = 700;
  // Cycle counts derived from the clock rate
  localparam int unsigned TX_DOM_TO_CYC   = TX_DOM_TO_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BUS_DOM_TO_CYC  = BUS_DOM_TO_US * (CLK_HZ / 1_000_000);
  // Least bit time in cycles, rounded down
  localparam int unsigned BIT_CYC_MIN     = CLK_HZ / BIT_RATE_MAX;
  // Mismatch events that trip a detector
  localparam int unsigned MISS_LIMIT      = 4;
  // Echo must follow within this many cycles of a dominant edge
  localparam int unsigned ECHO_WAIT_CYC   = 16;
  // ==========================================================================
  // Bus levels
  // ==========================================================================
  localparam logic LVL_DOM = 1'b0;
  localparam logic LVL_REC = 1'b1;
endpackage

/* File: src/cfg_miss_cnt.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Follow checker: counts dominant edges the watched line fails to follow
// ============================================================================
module cfg_miss_cnt
  import cfg_pkg::*;
#(
  parameter int unsigned WAIT_CYC = ECHO_WAIT_CYC,
  parameter int unsigned LIMIT    = MISS_LIMIT
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Control
  input  wire logic enable,
  input  wire logic clear,
  // Observed lines
  input  wire logic tx_fall,
  input  wire logic watched,
  // Result
  output logic      trip
);
  localparam int W = $clog2(WAIT_CYC + 1);
  localparam int C = $clog2(LIMIT + 1);
  logic [W-1:0] win_ff;
  logic [C-1:0] cnt_ff;
  logic         armed_ff;

  // ==========================================================================
  // Window after each dominant edge
  // ==========================================================================
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      armed_ff <= 1'b0;
      win_ff   <= '0;
    end else if (!enable || clear) begin
      armed_ff <= 1'b0;
      win_ff   <= '0;
    end else if (tx_fall) begin
      armed_ff <= 1'b1;
      win_ff   <= W'(WAIT_CYC);
    end else if (armed_ff && (watched == LVL_DOM || win_ff == '0)) begin
      armed_ff <= 1'b0;
    end else if (armed_ff) begin
      win_ff <= win_ff - 1'b1;
    end
  end

  // ==========================================================================
  // Miss counter, saturates at the limit
  // ==========================================================================
  // counter returns zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (!enable || clear) begin
      cnt_ff <= '0;
    end else if (armed_ff && !tx_fall && watched == LVL_DOM) begin
      cnt_ff <= '0;                       // Line followed: streak broken
    end else if (armed_ff && !tx_fall && win_ff == '0 && cnt_ff != C'(LIMIT)) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // Trip is the single cycle of the miss that reaches the limit; a level here
  // would hold the status latch through every clear, since a set wins
  assign trip = armed_ff && !tx_fall && (watched != LVL_DOM) && (win_ff == '0)
                && (cnt_ff == C'(LIMIT - 1));
endmodule // cfg_miss_cnt
`default_nettype wire

/* File: test/cfg_guard_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Port checks for the fault guard
module cfg_guard_sva
  import cfg_pkg::*;
#(
  parameter int unsigned TX_TO_CYC  = 50,
  parameter int unsigned BUS_TO_CYC = 50
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Inputs
  input wire logic can_tx,
  input wire logic bus_rx,
  input wire logic rx_echo,
  input wire logic rst_pin_ok,
  input wire logic fault_guard_off,
  input wire logic status_clear,
  // Outputs
  input wire logic can_rx,
  input wire logic bus_drive_n,
  input wire logic can_error,
  input wire logic err_tx_timeout,
  input wire logic err_bus_rec,
  input wire logic err_bus_dom,
  input wire logic err_rx_rec,
  input wire logic tx_off
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic        any_err;
  logic [15:0] txlow_ff;
  logic [15:0] buslow_ff;
  assign any_err = err_tx_timeout | err_bus_rec | err_bus_dom | err_rx_rec;
  // Dominant run lengths; only a lower bound, the design may start later
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txlow_ff  <= 16'h0;
      buslow_ff <= 16'h0;
    end else begin
      txlow_ff  <= can_tx ? 16'h0 : txlow_ff + 16'h1;
      buslow_ff <= bus_rx ? 16'h0 : buslow_ff + 16'h1;
    end
  end
  drive_follow_a: assert property (rst_pin_ok && !tx_off |=> bus_drive_n == $past(can_tx))
    else $error("driver does not follow transmit input");
  rx_copy_a: assert property (can_rx == $past(bus_rx))
    else $error("receive output does not follow bus");
  pin_hold_a: assert property (!rst_pin_ok |=> bus_drive_n)
    else $error("bus driven before reset pin condition");
  off_hold_a: assert property (tx_off |=> bus_drive_n)
    else $error("bus driven while transmitter off");
  err_share_a: assert property (any_err |=> can_error)
    else $error("shared error flag missing");
  dom_keep_a: assert property ($rose(err_bus_dom) && !(any_err ^ err_bus_dom) |=> !tx_off)
    else $error("bus dominant fault shut transmitter");
  guard_off_a: assert property ($past(fault_guard_off) |-> !$rose(any_err))
    else $error("fault latched while guard disabled");
  clear_only_a: assert property ($fell(tx_off) |-> $past(status_clear, 2))
    else $error("transmitter released without clear");
  tx_time_a: assert property ($rose(err_tx_timeout) |-> txlow_ff >= TX_TO_CYC)
    else $error("transmit time-out too early");
  bus_time_a: assert property ($rose(err_bus_dom) |-> buslow_ff >= BUS_TO_CYC)
    else $error("bus dominant time-out too early");
endmodule // cfg_guard_sva
bind cfg_guard cfg_guard_sva #(.TX_TO_CYC(TX_TO_CYC), .BUS_TO_CYC(BUS_TO_CYC)) u_sva (
  .clk_sys(clk_sys), .rst_n(rst_n), .can_tx(can_tx), .bus_rx(bus_rx),
  .rx_echo(rx_echo), .rst_pin_ok(rst_pin_ok), .fault_guard_off(fault_guard_off),
  .status_clear(status_clear), .can_rx(can_rx), .bus_drive_n(bus_drive_n),
  .can_error(can_error), .err_tx_timeout(err_tx_timeout), .err_bus_rec(err_bus_rec),
  .err_bus_dom(err_bus_dom), .err_rx_rec(err_rx_rec), .tx_off(tx_off));
`default_nettype wire

/* File: test/cfg_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Bus and front end seen from the guard
module cfg_bus_model (
  // Clock
  input  wire logic       clk_sys,
  // Scenario: 0 follow, 1 bus stuck recessive, 2 echo stuck, 3 bus stuck dominant
  input  wire logic [1:0] mode,
  // Front end lines
  input  wire logic       bus_drive_n,
  output logic            bus_rx,
  output logic            rx_echo
);
  logic drv_ff = 1'b1;
  // One clock stands in for the analog loop delay
  always_ff @(posedge clk_sys) drv_ff <= bus_drive_n;
  assign bus_rx  = (mode == 2'h1) ? 1'b1 : (mode == 2'h3) ? 1'b0 : drv_ff;
  assign rx_echo = (mode == 2'h2) ? 1'b1 : drv_ff;
endmodule // cfg_bus_model
`default_nettype wire

/* File: test/test_can_transceiver_fault_guard.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Self-checking bench for the fault guard
module test_can_transceiver_fault_guard;
  import cfg_pkg::*;
  localparam int unsigned TX_TO = 50;
  localparam int unsigned BUS_TO = 80;  // Above TX_TO so one fault shows at a time
  localparam int unsigned BIT_CYC = CLK_HZ / BIT_RATE_MAX;
  logic clk_sys, rst_n, can_tx, rst_pin_ok, fault_guard_off, status_clear;
  logic can_rx, bus_rx, rx_echo, bus_drive_n, can_error, tx_off;
  logic err_tx_timeout, err_bus_rec, err_bus_dom, err_rx_rec;
  logic [1:0] mode;
  int n_errors, n_checks;
  cfg_guard #(.TX_TO_CYC(TX_TO), .BUS_TO_CYC(BUS_TO)) uut (.clk_sys(clk_sys),
    .rst_n(rst_n), .can_tx(can_tx), .can_rx(can_rx), .bus_rx(bus_rx), .rx_echo(rx_echo),
    .bus_drive_n(bus_drive_n), .rst_pin_ok(rst_pin_ok), .fault_guard_off(fault_guard_off),
    .status_clear(status_clear), .can_error(can_error), .err_tx_timeout(err_tx_timeout),
    .err_bus_rec(err_bus_rec), .err_bus_dom(err_bus_dom), .err_rx_rec(err_rx_rec),
    .tx_off(tx_off));
  cfg_bus_model u_bus (.clk_sys(clk_sys), .mode(mode), .bus_drive_n(bus_drive_n),
    .bus_rx(bus_rx), .rx_echo(rx_echo));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Status: error, four latches, shutdown, driver
  task automatic st(input logic [6:0] exp);
    chk({can_error, err_tx_timeout, err_bus_rec, err_bus_dom, err_rx_rec, tx_off,
         bus_drive_n}, exp);
  endtask
  // one bit at the top rate
  task automatic bitx(input logic v);
    @(posedge clk_sys) can_tx <= v;
    tick(BIT_CYC - 1);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin bitx(1'b0); bitx(1'b1); end
  endtask
  task automatic set_mode(input logic [1:0] m);
    @(posedge clk_sys) mode <= m;
  endtask
  task automatic clr();
    @(posedge clk_sys) status_clear <= 1'b1;
    @(posedge clk_sys) status_clear <= 1'b0;
    tick(3);
    st(7'h01);
  endtask
  task automatic t_pin();
    bitx(1'b0);
    st(7'h01);
    @(posedge clk_sys) rst_pin_ok <= 1'b1;
    bitx(1'b1);
  endtask
  task automatic t_follow();
    logic [5:0] pat;
    // No two dominant bits in a row: the short bench time-out is under two bits
    pat = 6'h2d;
    for (int i = 0; i < 6; i++) begin
      bitx(pat[i]);
      chk({5'h0, bus_drive_n, can_rx}, {5'h0, pat[i], pat[i]});
    end
    st(7'h01);
  endtask
  task automatic t_txto();
    @(posedge clk_sys) can_tx <= 1'b0;
    tick(TX_TO + 6);
    st(7'h63);
    bitx(1'b1);
    bitx(1'b0);
    st(7'h63);
    bitx(1'b1);
    clr();
  endtask
  task automatic t_rec();
    set_mode(2'h1);
    pulses(3);
    set_mode(2'h0);
    pulses(1);
    set_mode(2'h1);
    pulses(3);
    st(7'h01);
    pulses(1);
    st(7'h53);
    set_mode(2'h0);
    clr();
  endtask
  task automatic t_echo();
    set_mode(2'h2);
    pulses(4);
    st(7'h47);
    set_mode(2'h0);
    clr();
  endtask
  task automatic t_dom();
    set_mode(2'h3);
    tick(BUS_TO + 6);
    st(7'h49);
    chk({6'h0, can_rx}, 7'h00);
    set_mode(2'h0);
    tick(2);
    clr();
  endtask
  task automatic t_off();
    @(posedge clk_sys) fault_guard_off <= 1'b1;
    bitx(1'b0);
    tick(TX_TO);
    bitx(1'b1);
    set_mode(2'h1);
    pulses(4);
    st(7'h01);
    set_mode(2'h0);
    @(posedge clk_sys) fault_guard_off <= 1'b0;
  endtask
  task automatic final_report();
    if (n_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Clock at 40 MHz
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Cuts a hang; the tests need well under 100 us
  initial begin
    #500us;
    n_errors++;
    final_report();
  end
  // Main sequence
  initial begin
    {rst_n, rst_pin_ok, fault_guard_off, status_clear, mode} = 6'h0;
    can_tx = 1'b1;
    n_errors = 0;
    n_checks = 0;
    tick(12);
    @(posedge clk_sys) rst_n <= 1'b1;
    t_pin();
    t_follow();
    t_txto();
    t_rec();
    t_echo();
    t_dom();
    t_off();
    final_report();
  end
endmodule // test_can_transceiver_fault_guard
`default_nettype wire
